// ---- include/move_mul_consts.svh ----
// constants for the move/multiply decode slice
// assumes nothing beyond a SystemVerilog compiler
`ifndef MOVE_MUL_CONSTS_SVH
`define MOVE_MUL_CONSTS_SVH
`define OPC_ESCAPE 8'h0F
`define OPC_CR_WRITE 8'h22
`define OPC_CR_READ 8'h20
`define OPC_DR_WRITE 8'h23
`define OPC_DR_READ 8'h21
`define OPC_TR_WRITE 8'h26
`define OPC_TR_READ 8'h24
`define OPC_SEG_LOAD 8'h8E
`define OPC_SEG_STORE 8'h8C
`define OPC_ACC_HI 4'hA
`define OPC_IMM_HI 4'hB
`define OPC_EXT_HI 4'hB
`define OPC_MUL_HI 7'h7B
`define MUL_REG_FIELD 3'h4
`define MODRM_REG_ONLY 2'h3
`define CLK_CR0_WR_REAL 8'h14
`define CLK_CR0_WR_PROT 8'h12
`define CLK_CR2_WR 8'h05
`define CLK_CR3_WR_REAL 8'h05
`define CLK_CR3_WR_PROT 8'h06
`define CLK_CR_RD 8'h06
`define CLK_DR_WR 8'h0A
`define CLK_DR_RD 8'h09
`define CLK_TRC_WR 8'h10
`define CLK_TRC_RD 8'h08
`define CLK_TRT_WR 8'h0B
`define CLK_TRT_RD 8'h03
`define CLK_SEG_LOAD_PROT 8'h06
`define CLK_ONE 8'h01
`define CLK_MUL_B 8'h04
`define CLK_MUL_W 8'h05
`define CLK_MUL_D 8'h0F
`endif

// ---- include/move_mul_pkg.sv ----
// types for the move/multiply decode slice
// assumes the constants header is on the include path
package move_mul_pkg;
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_CR_WRITE = 4'h1,
      OP_CR_READ = 4'h2,
      OP_DR_WRITE = 4'h3,
      OP_DR_READ = 4'h4,
      OP_TR_WRITE = 4'h5,
      OP_TR_READ = 4'h6,
      OP_SEG_LOAD = 4'h7,
      OP_SEG_STORE = 4'h8,
      OP_ACC_LOAD = 4'h9,
      OP_ACC_STORE = 4'hA,
      OP_IMM_LOAD = 4'hB,
      OP_SIGN_EXT = 4'hC,
      OP_ZERO_EXT = 4'hD,
      OP_UMUL = 4'hE
   } op_class_t;

   typedef enum logic [1:0] {
      W_BYTE = 2'h0,
      W_WORD = 2'h1,
      W_DWORD = 2'h2
   } op_width_t;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      logic [7:0] modrm;
      logic prot_mode;
      logic opsize32;
   } fetch_word_t;

   typedef struct packed {
      op_class_t op_class;
      op_width_t width;
      logic [2:0] src_sel;
      logic [2:0] dst_sel;
      logic uses_modrm;
      logic [7:0] clocks;
      logic [3:0] flag_write;
      logic [1:0] flag_undef;
      logic illegal;
   } decode_word_t;

   typedef enum logic [1:0] {
      F_IDLE = 2'h0,
      F_HOLD = 2'h1
   } issue_state_t;
endpackage : move_mul_pkg

// ---- hw/move_mul_classify.sv ----
// combinational classifier for one instruction's opcode bytes
// assumes bytes are already aligned by the fetch stage
`timescale 1ns/100ps
`default_nettype none
`include "move_mul_consts.svh"
module move_mul_classify
   import move_mul_pkg::*;
(
   // fetched bytes
   input wire fetch_word_t fetch_in,
   // classification
   output decode_word_t decode_out
);
   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] m;
   logic [2:0] eee;
   op_width_t full_w;

   always_comb begin
      decode_word_t d;
      d = '0;
      b0 = fetch_in.first;
      b1 = fetch_in.second;
      m = fetch_in.modrm;
      eee = m[5:3];
      full_w = fetch_in.opsize32 ? W_DWORD : W_WORD;
      d.op_class = OP_NONE;
      d.width = W_DWORD;
      d.clocks = `CLK_ONE;
      d.illegal = 1'b1;
      if (b0 == `OPC_ESCAPE) begin
         d.src_sel = m[2:0];
         d.dst_sel = eee;
         d.uses_modrm = 1'b1;
         unique case (b1)
            `OPC_CR_WRITE: begin
               d.op_class = OP_CR_WRITE; // [RULE1]
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               unique case (eee) // [RULE2]
                  3'h0: d.clocks = fetch_in.prot_mode ?
                     `CLK_CR0_WR_PROT : `CLK_CR0_WR_REAL;
                  3'h2: d.clocks = `CLK_CR2_WR;
                  default: d.clocks = fetch_in.prot_mode ?
                     `CLK_CR3_WR_PROT : `CLK_CR3_WR_REAL;
               endcase
            end
            `OPC_CR_READ: begin
               d.op_class = OP_CR_READ; // [RULE1]
               d.src_sel = eee;
               d.dst_sel = m[2:0];
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               d.clocks = `CLK_CR_RD; // [RULE2]
            end
            `OPC_DR_WRITE: begin
               d.op_class = OP_DR_WRITE;
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               d.clocks = `CLK_DR_WR; // [RULE3]
            end
            `OPC_DR_READ: begin
               d.op_class = OP_DR_READ;
               d.src_sel = eee;
               d.dst_sel = m[2:0];
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               d.clocks = `CLK_DR_RD; // [RULE3]
            end
            `OPC_TR_WRITE: begin
               d.op_class = OP_TR_WRITE;
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               d.clocks = (eee >= 3'h6) ? `CLK_TRT_WR : `CLK_TRC_WR; // [RULE4]
            end
            `OPC_TR_READ: begin
               d.op_class = OP_TR_READ;
               d.src_sel = eee;
               d.dst_sel = m[2:0];
               d.illegal = m[7:6] != `MODRM_REG_ONLY;
               d.clocks = (eee >= 3'h6) ? `CLK_TRT_RD : `CLK_TRC_RD; // [RULE4]
            end
            8'hBE, 8'hBF: begin
               d.op_class = OP_SIGN_EXT; // [RULE10]
               d.width = b1[0] ? W_WORD : W_BYTE;
               d.illegal = 1'b0;
            end
            8'hB6, 8'hB7: begin
               d.op_class = OP_ZERO_EXT; // [RULE11]
               d.width = b1[0] ? W_WORD : W_BYTE;
               d.illegal = 1'b0;
            end
            default: d.illegal = 1'b1;
         endcase
      end else if (b0 == `OPC_SEG_LOAD) begin
         d.op_class = OP_SEG_LOAD; // [RULE5]
         d.width = W_WORD;
         d.uses_modrm = 1'b1;
         d.src_sel = m[2:0];
         d.dst_sel = eee;
         d.illegal = 1'b0;
         d.clocks = fetch_in.prot_mode ? `CLK_SEG_LOAD_PROT : `CLK_ONE;
      end else if (b0 == `OPC_SEG_STORE) begin
         d.op_class = OP_SEG_STORE; // [RULE6]
         d.width = W_WORD;
         d.uses_modrm = 1'b1;
         d.src_sel = eee;
         d.dst_sel = m[2:0];
         d.illegal = 1'b0;
      end else if (b0[7:4] == `OPC_ACC_HI && b0[3:1] == 3'h0) begin
         d.op_class = OP_ACC_LOAD; // [RULE7]
         d.width = b0[0] ? full_w : W_BYTE;
         d.illegal = 1'b0;
      end else if (b0[7:4] == `OPC_ACC_HI && b0[3:1] == 3'h1) begin
         d.op_class = OP_ACC_STORE; // [RULE8]
         d.width = b0[0] ? full_w : W_BYTE;
         d.illegal = 1'b0;
      end else if (b0[7:4] == `OPC_IMM_HI) begin
         d.op_class = OP_IMM_LOAD; // [RULE9]
         d.width = b0[3] ? full_w : W_BYTE;
         d.dst_sel = b0[2:0];
         d.illegal = 1'b0;
      end else if (b0[7:1] == `OPC_MUL_HI && eee == `MUL_REG_FIELD) begin
         d.op_class = OP_UMUL; // [RULE12]
         d.uses_modrm = 1'b1;
         d.src_sel = m[2:0];
         d.width = b0[0] ? full_w : W_BYTE;
         d.flag_write = 4'hF;
         d.flag_undef = 2'h3;
         d.illegal = 1'b0;
         unique case (d.width)
            W_BYTE: d.clocks = `CLK_MUL_B;
            W_WORD: d.clocks = `CLK_MUL_W;
            default: d.clocks = `CLK_MUL_D;
         endcase
      end
      decode_out = d;
   end
endmodule : move_mul_classify
`default_nettype wire

// ---- hw/move_mul_decoder.sv ----
// registered decoder for the move/multiply instruction slice
// How it works
// RULE1: 0F 22 writes, 0F 20 reads a control register, register form.
// RULE2: control write costs 20/5/5 real, 18/5/6 protected; read costs 6.
// RULE3: debug writes 0F 23 take 10 clocks; reads 0F 21 take 9.
// RULE4: test writes 0F 26 cost 16 or 11; reads 0F 24 cost 8 or 3.
// RULE5: 8E loads a segment register; 1 clock real, 6 protected.
// RULE6: 8C stores a segment selector; one clock in both modes.
// RULE7: A0/A1 load accumulator from direct offset, one clock.
// RULE8: A2/A3 store accumulator to direct offset, one clock.
// RULE9: B0-BF load immediate; bit 3 width, low bits register.
// RULE10: 0F BE/BF sign-extend into register, one clock, flags kept.
// RULE11: 0F B6/B7 zero-extend into register, one clock, flags kept.
// RULE12: F6/F7 /4 multiply takes 4/5/15; writes OF SF ZF CF.
// RULE13: each decode delivers class, width, selectors and clock count.
// assumes the fetch stage holds bytes until ready_out is high
`timescale 1ns/100ps
`default_nettype none
`include "move_mul_consts.svh"
module move_mul_decoder
   import move_mul_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // from fetch
   input wire logic fetch_valid_in,
   input wire fetch_word_t fetch_in,
   output logic ready_out,
   // to execution
   output logic issue_valid_out,
   output decode_word_t issue_out,
   output logic busy_out
);
   decode_word_t cls;
   decode_word_t issue_reg, issue_next;
   logic valid_reg, valid_next;
   logic ready_reg, ready_next;
   logic [7:0] count_reg, count_next;
   logic busy_reg, busy_next;
   issue_state_t state_reg, state_next;

   move_mul_classify u_classify (
      .fetch_in(fetch_in),
      .decode_out(cls)
   );

   // one decode issued, then held for its clock count
   always_comb begin
      issue_next = issue_reg;
      valid_next = 1'b0;
      count_next = count_reg;
      state_next = state_reg;
      ready_next = ready_reg;
      unique case (state_reg)
         F_IDLE: begin
            if (fetch_valid_in && ready_reg) begin
               issue_next = cls; // [RULE13]
               valid_next = 1'b1;
               if (cls.clocks > `CLK_ONE) begin
                  count_next = cls.clocks - `CLK_ONE; // [RULE2] [RULE12]
                  state_next = F_HOLD;
                  ready_next = 1'b0;
               end
            end
         end
         F_HOLD: begin
            count_next = count_reg - `CLK_ONE;
            if (count_reg == `CLK_ONE) begin
               state_next = F_IDLE;
               ready_next = 1'b1; // [RULE2] [RULE12]
            end
         end
         default: begin
            state_next = F_IDLE;
            ready_next = 1'b1;
         end
      endcase
      busy_next = state_next == F_HOLD;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         issue_reg <= '0;
         valid_reg <= 1'b0;
         count_reg <= 8'h00;
         state_reg <= F_IDLE;
         ready_reg <= 1'b1;
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
         issue_reg <= issue_next;
         valid_reg <= valid_next;
         count_reg <= count_next;
         state_reg <= state_next;
         ready_reg <= ready_next;
      end
   end

   assign ready_out = ready_reg;
   assign issue_valid_out = valid_reg;
   assign issue_out = issue_reg;
   assign busy_out = busy_reg;
endmodule : move_mul_decoder
`default_nettype wire

// ---- verif/move_mul_decoder_sva.sv ----
// assertions on the move/multiply decoder ports
// assumes it is bound to every decoder instance
`timescale 1ns/100ps
`default_nettype none
module move_mul_decoder_sva
   import move_mul_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // decoder ports
   input wire logic fetch_valid_in,
   input wire fetch_word_t fetch_in,
   input wire logic ready_out,
   input wire logic issue_valid_out,
   input wire decode_word_t issue_out,
   input wire logic busy_out
);
   wire logic take = fetch_valid_in && ready_out;
   logic [7:0] cnt_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // edges since the last take, saturating
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) cnt_reg <= 8'hFF;
      else cnt_reg <= take ? 8'h01 : cnt_reg + {7'h00, cnt_reg != 8'hFF};
   end
   sequence s_op(logic [7:0] op);
      take && fetch_in.first == op;
   endsequence
   sequence s_issue;
      ##1 issue_valid_out;
   endsequence
   a_issue_after:
      assert property (take |-> s_issue) else $error("no issue");
   a_issue_held:
      assert property (!take |=> !issue_valid_out && $stable(issue_out))
      else $error("issue without take");
   a_ready_spacing:
      assert property (ready_out == (cnt_reg >= issue_out.clocks))
      else $error("ready spacing");
   a_busy_window:
      assert property (busy_out == (cnt_reg < issue_out.clocks))
      else $error("busy window");
   a_cr0_cost:
      assert property (s_op(8'h0F) ##0 fetch_in.second == 8'h22 &&
         fetch_in.modrm[7:3] == 5'h18 |=> issue_out.clocks ==
         ($past(fetch_in.prot_mode) ? 8'h12 : 8'h14)) else $error("cr0");
   a_seg_cost:
      assert property (s_op(8'h8E) ##0 fetch_in.modrm[5:3] == 3'h3 |=>
         issue_out.clocks == ($past(fetch_in.prot_mode) ? 8'h06 : 8'h01))
      else $error("segment load");
   a_umul_flags:
      assert property (take && fetch_in.first[7:1] == 7'h7B &&
         fetch_in.modrm[5:3] == 3'h4 |=> issue_out.op_class == OP_UMUL &&
         issue_out.flag_write == 4'hF && issue_out.flag_undef == 2'h3)
      else $error("multiply flags");
   a_ext_flags:
      assert property (s_op(8'h0F) ##0 fetch_in.second[7:4] == 4'hB &&
         fetch_in.second[2:1] == 2'h3 |=> issue_out.flag_write == 4'h0 &&
         issue_out.clocks == 8'h01) else $error("extension move");
endmodule : move_mul_decoder_sva
bind move_mul_decoder move_mul_decoder_sva chk_u (.clk_in(clk_in),
   .resetn_in(resetn_in), .fetch_valid_in(fetch_valid_in),
   .fetch_in(fetch_in), .ready_out(ready_out),
   .issue_valid_out(issue_valid_out), .issue_out(issue_out),
   .busy_out(busy_out));
`default_nettype wire

// ---- verif/fetch_source.sv ----
// fetch stage model: offers one instruction word until it is taken
// assumes the decoder takes it on a rising edge with ready high
`timescale 1ns/100ps
`default_nettype none
module fetch_source
   import move_mul_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // from bench and decoder
   input wire logic load_in,
   input wire fetch_word_t word_in,
   input wire logic ready_in,
   // to decoder
   output logic valid_out = 1'h0,
   output fetch_word_t word_out = '0
);
   logic taken_reg = 1'h0;
   always @(posedge clk_in) taken_reg <= valid_out && ready_in;
   // released bytes are inverted, not left standing
   always @(negedge clk_in or negedge resetn_in) begin
      if (!resetn_in) valid_out <= 1'h0;
      else if (load_in) {valid_out, word_out} <= {1'h1, word_in};
      else if (taken_reg) {valid_out, word_out} <= {1'h0, ~word_out};
   end
endmodule : fetch_source
`default_nettype wire

// ---- verif/test_x86_move_multiply_decoder.sv ----
// self-checking bench for the move/multiply decoder
// assumes the checker and the fetch model are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_x86_move_multiply_decoder;
   import move_mul_pkg::*;
   logic clk_in = 1'h0, resetn_in = 1'h0, load = 1'h0;
   logic fv, ready, ivalid, busy;
   fetch_word_t word = '0;
   fetch_word_t fw;
   decode_word_t dw;
   int errors = 0, tests_run = 0, cycles = 0;
   fetch_source src_u (.clk_in(clk_in), .resetn_in(resetn_in),
      .load_in(load), .word_in(word), .ready_in(ready), .valid_out(fv),
      .word_out(fw));
   move_mul_decoder dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
      .fetch_valid_in(fv), .fetch_in(fw), .ready_out(ready),
      .issue_valid_out(ivalid), .issue_out(dw), .busy_out(busy));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         summarize();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // offer one word, then judge class, cost and ready spacing
   task automatic run(input logic [7:0] a, b, m, input logic [1:0] mo,
      input op_class_t c, input logic [7:0] n);
      int k;
      @(negedge clk_in);
      word <= {a, b, m, mo};
      load <= 1'h1;
      @(negedge clk_in);
      load <= 1'h0;
      for (k = 0; k < 20 && ivalid !== 1'h1; k++)
         @(negedge clk_in);
      check({4'h0, dw.op_class}, {4'h0, c});
      check(dw.clocks, n);
      check({7'h0, busy}, {7'h0, n > 8'h01});
      for (k = 1; k < 40 && ready !== 1'h1; k++)
         @(negedge clk_in);
      check(8'(k), n);
   endtask : run
   task automatic t_ctrl();
      run(8'h0F,8'h22,8'hC0,2'h0,OP_CR_WRITE,8'h14);
      run(8'h0F,8'h22,8'hC0,2'h2,OP_CR_WRITE,8'h12);
      run(8'h0F,8'h22,8'hD0,2'h0,OP_CR_WRITE,8'h05);
      run(8'h0F,8'h22,8'hD8,2'h2,OP_CR_WRITE,8'h06);
      run(8'h0F,8'h20,8'hC0,2'h2,OP_CR_READ,8'h06);
   endtask : t_ctrl
   task automatic t_dbg_tst();
      run(8'h0F,8'h23,8'hC0,2'h0,OP_DR_WRITE,8'h0A);
      run(8'h0F,8'h21,8'hF8,2'h2,OP_DR_READ,8'h09);
      run(8'h0F,8'h26,8'hD8,2'h0,OP_TR_WRITE,8'h10);
      run(8'h0F,8'h24,8'hF8,2'h2,OP_TR_READ,8'h03);
   endtask : t_dbg_tst
   task automatic t_seg();
      run(8'h8E,8'hD8,8'hD8,2'h0,OP_SEG_LOAD,8'h01);
      run(8'h8E,8'hD8,8'hD8,2'h2,OP_SEG_LOAD,8'h06);
      run(8'h8C,8'hC8,8'hC8,2'h2,OP_SEG_STORE,8'h01);
   endtask : t_seg
   task automatic t_short();
      run(8'hA1,8'h00,8'h00,2'h1,OP_ACC_LOAD,8'h01);
      check({6'h0, dw.width}, {6'h0, W_DWORD});
      run(8'hA2,8'h00,8'h00,2'h3,OP_ACC_STORE,8'h01);
      check({6'h0, dw.width}, {6'h0, W_BYTE});
      run(8'hB3,8'h00,8'h00,2'h1,OP_IMM_LOAD,8'h01);
      check({6'h0, dw.width}, {6'h0, W_BYTE});
      check({5'h0, dw.dst_sel}, 8'h03);
      run(8'hBF,8'h00,8'h00,2'h1,OP_IMM_LOAD,8'h01);
      check({5'h0, dw.dst_sel}, 8'h07);
   endtask : t_short
   task automatic t_ext_mul();
      run(8'h0F,8'hBE,8'hC1,2'h1,OP_SIGN_EXT,8'h01);
      run(8'h0F,8'hB7,8'hC1,2'h1,OP_ZERO_EXT,8'h01);
      check({4'h0, dw.flag_write}, 8'h00);
      run(8'hF6,8'hE3,8'hE3,2'h1,OP_UMUL,8'h04);
      run(8'hF7,8'hE3,8'hE3,2'h2,OP_UMUL,8'h05);
      run(8'hF7,8'hE3,8'hE3,2'h3,OP_UMUL,8'h0F);
      check({2'h0, dw.flag_write, dw.flag_undef}, 8'h3F);
   endtask : t_ext_mul
   initial begin
      repeat (4) @(negedge clk_in);
      resetn_in <= 1'h1;
      t_ctrl();
      t_dbg_tst();
      t_seg();
      t_short();
      t_ext_mul();
      summarize();
   end
endmodule : test_x86_move_multiply_decoder
`default_nettype wire
